// file: common/pbs_cfg.svh
/*
 sizes, reset values and latency counts of the pipelined burst sram core.
 assumes it is included by the package and the core, nothing more.
*/
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH
`define PBS_ADDR_W 20
`define PBS_DATA_W 36
`define PBS_LANES 4
`define PBS_LANE_W 9
`define PBS_WORDS 1048576
`define PBS_RD_LAT 3
`define PBS_ALL_LANES 4'hF
`define PBS_NO_LANES 4'h0
`define PBS_OFS_RST 2'h0
`define PBS_OFS_STEP 2'h1
`endif

// file: common/pbs_pkg.sv
/*
 types shared by the pipelined burst sram core.
 assumes pbs_cfg.svh is on the include path.
*/
`include "pbs_cfg.svh"
package pbs_pkg;
   typedef logic [`PBS_ADDR_W-1:0] pbs_addr_t;
   typedef logic [`PBS_DATA_W-1:0] pbs_word_t;
   typedef logic [`PBS_LANES-1:0] pbs_lane_t;
   typedef struct packed {
      logic valid;
      logic write;
      pbs_addr_t addr;
      pbs_word_t data;
      pbs_lane_t lanes;
   } pbs_cmd_s;
   typedef struct packed {
      logic valid;
      pbs_word_t data;
   } pbs_rd_s;
   typedef enum logic [1:0] {
      PBS_IDLE = 2'b01,
      PBS_BURST = 2'b10
   } pbs_state_e;
endpackage : pbs_pkg

// file: verilog/pbs_sram_core.sv
/*
 pipelined burst synchronous sram core, 1M words of 36 bits, four 9-bit lanes.
 assumes a synchronous bus master on the pins; output enable is folded into
 the drive enable without a clock, the pad logic outside resolves the wire.
*/
// Notes on behaviour
// R01 - storage is 1M words of 36 bits; data width follows that organisation.
// R02 - all synchronous inputs are sampled only at the rising clock edge.
// R03 - address and chip enables captured only when an address strobe is active.
// R04 - a two-bit burst counter seeded from the address gives later low bits.
// R05 - advance steps the burst counter; without advance the counter holds.
// R06 - burst order is interleaved or linear as the user selects.
// R07 - order select low means linear; high or floating means interleaved; the core has no pull-up and selects interleaved only on a driven high.
// R08 - writes register address, data, controls, then finish in the array alone.
// R09 - a lane is written only with its lane enable and the byte qualifier.
// R10 - global write low writes every lane regardless of the lane enables.
// R11 - output enable acts without a clock and gates the drivers; sleep is sampled at the clock edge like a deselect.
// R12 - read data leaves through a registered output stage.
// R13 - first burst word three clocks after capture, then one per clock.
// R14 - the burst wraps inside its aligned group of four words.
// R15 - outputs go idle one clock after a deselect is sampled.
`timescale 1ns/10ps
`include "pbs_cfg.svh"
module pbs_sram_core
   import pbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire pbs_addr_t addr,
   input wire pbs_word_t dq_in,
   input wire logic processor_address_strobe_b,
   input wire logic controller_address_strobe_b,
   input wire logic burst_advance_b,
   input wire pbs_lane_t byte_lane_write_enable_b,
   input wire logic byte_write_qualifier_b,
   input wire logic global_write_b,
   input wire logic pipelined_chip_select_b,
   input wire logic depth_expansion_select_high,
   input wire logic depth_expansion_select_low_b,
   input wire logic output_enable_b,
   input wire logic sleep_request,
   input wire logic burst_order_select,
   output pbs_word_t dq_out,
   output logic dq_drive_b
);
   logic [`PBS_DATA_W-1:0] mem [0:`PBS_WORDS-1]; // [R01]
   pbs_state_e state;
   pbs_state_e next_state;
   logic [`PBS_ADDR_W-1:2] base;
   logic [1:0] seed;
   logic [1:0] ofs;
   logic [1:0] next_ofs;
   pbs_cmd_s cmd;
   pbs_cmd_s next_cmd;
   pbs_rd_s rd_arr;
   pbs_rd_s rd_mid;
   pbs_rd_s rd_out;

   // processor strobe is ignored while the pipelined select is off
   wire proc_go = ~processor_address_strobe_b & ~pipelined_chip_select_b;
   wire ctrl_go = ~controller_address_strobe_b & ~proc_go;
   wire start = (proc_go | ctrl_go) & ~sleep_request; // [R03]
   wire sel_in = ~pipelined_chip_select_b & depth_expansion_select_high
      & ~depth_expansion_select_low_b;
   wire desel_evt = (start & ~sel_in) | sleep_request; // [R11]
   wire open_burst = start & sel_in;
   wire in_burst = (state == PBS_BURST) & ~start & ~sleep_request;
   wire step = in_burst & ~burst_advance_b; // [R05]

   // lane decode: global write overrides, else lane enable qualified
   wire pbs_lane_t lane_req = ~global_write_b ? `PBS_ALL_LANES // [R10]
      : (~byte_write_qualifier_b ? ~byte_lane_write_enable_b : `PBS_NO_LANES); // [R09]
   wire wr_any = lane_req != `PBS_NO_LANES;

   // a processor-strobe start is always a read; a write follows on the next
   // cycle at the held address, as the bus master expects
   wire start_wr = ctrl_go & wr_any; // [R08]

   // counter wraps in two bits, so a burst stays in its aligned four words
   wire [1:0] sel_seed = open_burst ? addr[1:0] : seed;
   wire [1:0] lin_low = 2'(sel_seed + next_ofs); // [R14]
   wire [1:0] ilv_low = sel_seed ^ next_ofs;
   wire [1:0] cur_low = burst_order_select ? ilv_low : lin_low; // [R06] [R07]
   wire [`PBS_ADDR_W-1:2] cur_base = open_burst ? addr[`PBS_ADDR_W-1:2] : base;

   always_comb
   begin
      next_state = state;
      next_ofs = ofs;
      next_cmd = '0;
      if (desel_evt)
      begin
         next_state = PBS_IDLE;
      end
      else if (open_burst)
      begin
         next_state = PBS_BURST;
         next_ofs = `PBS_OFS_RST; // [R04]
         next_cmd.valid = 1'b1;
         next_cmd.write = start_wr;
      end
      else if (in_burst)
      begin
         if (step)
         begin
            next_ofs = 2'(ofs + `PBS_OFS_STEP); // [R04] [R05]
         end
         next_cmd.valid = 1'b1;
         next_cmd.write = wr_any;
      end
      else
      begin
         next_state = state;
      end
      next_cmd.addr = {cur_base, cur_low};
      next_cmd.data = dq_in;
      next_cmd.lanes = next_cmd.write ? lane_req : `PBS_NO_LANES;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         state <= PBS_IDLE;
         ofs <= `PBS_OFS_RST;
         cmd <= '0;
      end
      else
      begin
         state <= next_state;
         ofs <= next_ofs;
         cmd <= next_cmd; // [R02] [R08]
      end
   end

   // address and seed only load at a strobe with the chip selected
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         base <= '0;
         seed <= `PBS_OFS_RST;
      end
      else if (open_burst)
      begin
         base <= addr[`PBS_ADDR_W-1:2]; // [R03]
         seed <= addr[1:0]; // [R04]
      end
   end

   // self-timed array write one clock after the command; a read of the same
   // word in the next command sees it, so no bypass path is needed
   // one process owns the array, so the lanes never become separate drivers
   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < `PBS_LANES; i++)
      begin
         if (cmd.valid & cmd.lanes[i])
         begin
            mem[cmd.addr][i*`PBS_LANE_W +: `PBS_LANE_W] <=
               cmd.data[i*`PBS_LANE_W +: `PBS_LANE_W]; // [R08] [R09]
         end
      end
   end

   // three register stages after capture; a deselect flushes the first two so the
   // pins idle one clock later instead of draining the whole pipe
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b | desel_evt)
      begin
         rd_arr <= '0;
         rd_mid <= '0;
      end
      else
      begin
         rd_arr.valid <= cmd.valid & ~cmd.write;
         rd_arr.data <= mem[cmd.addr];
         rd_mid <= rd_arr; // [R13]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         rd_out <= '0;
      end
      else
      begin
         rd_out <= rd_mid; // [R12] [R15]
      end
   end

   assign dq_out = rd_out.data;
   // enable acts at once; trade-off is one gate between flop and driver
   assign dq_drive_b = ~(rd_out.valid & ~output_enable_b); // [R11]

   sequence s_read_open;
      open_burst & ~start_wr;
   endsequence

   sequence s_burst_read;
      in_burst & ~wr_any;
   endsequence

   // no flush on the two edges that move the word through the pipe
   sequence s_held_two;
      (~desel_evt)[*2];
   endsequence

   // the word is registered at the third edge, so it is seen at the fourth
   property p_first_word;
      @(posedge sys_clk) disable iff (!rst_b)
         s_read_open ##1 s_held_two |=> ##1 rd_out.valid;
   endproperty

   a_first_word_latency: assert property (p_first_word) // [R13]
      else $error("first read word not out three clocks after capture");

   a_burst_next_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_burst_read ##1 s_held_two |=> ##1 rd_out.valid) // [R13]
      else $error("burst word missing one clock after previous");

   a_counter_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (in_burst & burst_advance_b) |=> $stable(ofs)) // [R05]
      else $error("burst counter moved without advance");

   a_counter_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
      step |=> ofs == 2'($past(ofs) + 2'h1)) // [R04]
      else $error("burst counter did not step on advance");

   a_capture_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ~open_burst |=> $stable(base) && $stable(seed)) // [R03]
      else $error("address captured without a strobe");

   a_deselect_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      desel_evt ##1 ~open_burst |=> ~rd_out.valid && dq_drive_b) // [R15]
      else $error("outputs still active after deselect");

   a_global_lanes: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (next_cmd.write & ~global_write_b) |=> cmd.lanes == `PBS_ALL_LANES) // [R10]
      else $error("global write did not select all lanes");

   a_lane_qualify: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (global_write_b & byte_write_qualifier_b) |=> cmd.lanes == `PBS_NO_LANES) // [R09]
      else $error("lane written without byte qualifier");

   a_processor_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (proc_go & sel_in & ~sleep_request) |=> cmd.valid && !cmd.write) // [R08]
      else $error("processor strobe start was not a read");

   a_wrap_group: assert property (@(posedge sys_clk) disable iff (!rst_b)
      in_burst |=> cmd.addr[`PBS_ADDR_W-1:2] == $past(base)) // [R14]
      else $error("burst left its aligned group of four");

   a_drive_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      output_enable_b |-> dq_drive_b) // [R11]
      else $error("drivers on while output enable is off");
endmodule : pbs_sram_core

// file: tb/pbs_bus_model.sv
/*
 bus master model that drives the strobe, advance, select, write, address and data inputs of the sram core through tasks.
 assumes its tasks are called just after a rising edge of sys_clk.
*/
`timescale 1ns/10ps
module pbs_bus_model
   import pbs_pkg::*;
(
   input wire logic sys_clk,
   output pbs_addr_t addr,
   output pbs_word_t dq_in,
   output logic processor_address_strobe_b,
   output logic controller_address_strobe_b,
   output logic burst_advance_b,
   output pbs_lane_t byte_lane_write_enable_b,
   output logic byte_write_qualifier_b,
   output logic global_write_b,
   output logic pipelined_chip_select_b,
   output logic depth_expansion_select_high,
   output logic depth_expansion_select_low_b,
   output logic output_enable_b,
   output logic sleep_request,
   output logic burst_order_select
);
   // the strobe, advance, chip select, write, address and data lines are written once per cycle; the next call replaces the values
   task automatic put(input logic p_b, input logic c_b, input logic adv_b, input logic cs_b,
      input pbs_lane_t lanes_b, input logic glob_b, input pbs_addr_t a, input pbs_word_t d);
   begin
      processor_address_strobe_b = p_b;
      controller_address_strobe_b = c_b;
      burst_advance_b = adv_b;
      pipelined_chip_select_b = cs_b;
      byte_lane_write_enable_b = lanes_b;
      byte_write_qualifier_b = &lanes_b;
      global_write_b = glob_b;
      addr = a;
      dq_in = d;
      @(posedge sys_clk);
      #1;
   end
   endtask : put
   task automatic start(input logic proc, input pbs_addr_t a, input logic cs_b,
      input pbs_lane_t lanes_b, input logic glob_b, input pbs_word_t d);
   begin
      put(~proc, proc, 1'b1, cs_b, lanes_b, glob_b, a, d);
   end
   endtask : start
   // released lines flip so that a stale value is never mistaken for a live one
   task automatic step(input logic burst_advance);
   begin
      put(1'b1, 1'b1, ~burst_advance, pipelined_chip_select_b, 4'hF, 1'b1, ~addr, ~dq_in);
   end
   endtask : step
   // burst cycle carrying write controls and data at the held address
   task automatic beat(input pbs_lane_t lanes_b, input logic glob_b, input pbs_word_t d);
   begin
      put(1'b1, 1'b1, 1'b1, pipelined_chip_select_b, lanes_b, glob_b, ~addr, d);
   end
   endtask : beat
   initial
   begin
      addr = 20'h00000;
      dq_in = 36'h000000000;
      output_enable_b = 1'b0;
      sleep_request = 1'b0;
      burst_order_select = 1'b1;
      pipelined_chip_select_b = 1'b1;
      depth_expansion_select_high = 1'b1;
      depth_expansion_select_low_b = 1'b0;
      processor_address_strobe_b = 1'b1;
      controller_address_strobe_b = 1'b1;
      burst_advance_b = 1'b1;
      byte_lane_write_enable_b = 4'hF;
      byte_write_qualifier_b = 1'b1;
      global_write_b = 1'b1;
   end
endmodule : pbs_bus_model

// file: tb/pbs_sram_core_test.sv
/*
 self-checking bench for the sram core, driven through the bus master model.
 assumes the core keeps its own timing assertions inside the design files.
*/
`timescale 1ns/10ps
module pbs_sram_core_test;
   import pbs_pkg::*;
   logic sys_clk, rst_b, dq_drive_b;
   pbs_addr_t addr;
   pbs_word_t dq_in, dq_out;
   pbs_lane_t byte_lane_write_enable_b;
   logic processor_address_strobe_b, controller_address_strobe_b, burst_advance_b;
   logic byte_write_qualifier_b, global_write_b, pipelined_chip_select_b;
   logic depth_expansion_select_high, depth_expansion_select_low_b;
   logic output_enable_b, sleep_request, burst_order_select;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   pbs_bus_model u_pbs_bus_model (.sys_clk, .addr, .dq_in, .processor_address_strobe_b,
      .controller_address_strobe_b, .burst_advance_b, .byte_lane_write_enable_b,
      .byte_write_qualifier_b, .global_write_b, .pipelined_chip_select_b,
      .depth_expansion_select_high, .depth_expansion_select_low_b, .output_enable_b,
      .sleep_request, .burst_order_select);
   pbs_sram_core u_pbs_sram_core (.sys_clk, .rst_b, .addr, .dq_in, .processor_address_strobe_b,
      .controller_address_strobe_b, .burst_advance_b, .byte_lane_write_enable_b,
      .byte_write_qualifier_b, .global_write_b, .pipelined_chip_select_b,
      .depth_expansion_select_high, .depth_expansion_select_low_b, .output_enable_b,
      .sleep_request, .burst_order_select, .dq_out, .dq_drive_b);
   task automatic finish_test();
   begin
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask : finish_test
   task automatic check(input pbs_word_t got, input pbs_word_t exp);
   begin
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask : check
   // a new strobe or sleep would also end a burst; every access here closes with a deselect
   task automatic wr(input pbs_addr_t a, input pbs_lane_t lb, input logic gw_b, input pbs_word_t d);
   begin
      u_pbs_bus_model.start(1'b0, a, 1'b0, lb, gw_b, d);
      u_pbs_bus_model.start(1'b0, a, 1'b1, 4'hF, 1'b1, d);
   end
   endtask : wr
   task automatic rd(input logic proc, input pbs_addr_t a, input pbs_word_t exp);
   begin
      u_pbs_bus_model.start(proc, a, 1'b0, 4'hF, 1'b1, 36'h000000000);
      u_pbs_bus_model.step(1'b0);
      u_pbs_bus_model.step(1'b0);
      check(pbs_word_t'(dq_drive_b), 36'h000000001);
      u_pbs_bus_model.step(1'b0);
      check(pbs_word_t'(dq_drive_b), 36'h000000000);
      check(dq_out, exp);
      u_pbs_bus_model.output_enable_b = 1'b1;
      #1;
      check(pbs_word_t'(dq_drive_b), 36'h000000001);
      @(posedge sys_clk);
      #1;
      u_pbs_bus_model.output_enable_b = 1'b0;
      u_pbs_bus_model.start(1'b0, a, 1'b1, 4'hF, 1'b1, 36'h000000000);
      check(pbs_word_t'(dq_drive_b), 36'h000000000);
      u_pbs_bus_model.step(1'b0);
      check(pbs_word_t'(dq_drive_b), 36'h000000001);
   end
   endtask : rd
   task automatic s_lanes();
   begin
      wr(20'h00010, 4'hF, 1'b0, 36'hFFFFFFFFF);
      rd(1'b0, 20'h00010, 36'hFFFFFFFFF);
      wr(20'h00010, 4'hD, 1'b1, 36'h000000000);
      rd(1'b1, 20'h00010, 36'hFFFFC01FF);
      wr(20'h00011, 4'hE, 1'b0, 36'h123456789);
      rd(1'b0, 20'h00011, 36'h123456789);
   end
   endtask : s_lanes
   task automatic s_burst(input logic order, input logic [2:0] pat);
      logic [1:0] ofs;
      logic [1:0] low;
      pbs_word_t e [4];
   begin
      ofs = 2'h0;
      for (int k = 0; k < 4; k++)
      begin
         if (k > 0)
            ofs = ofs + 2'(pat[k-1]);
         low = order ? (2'h2 ^ ofs) : (2'h2 + ofs);
         e[k] = {16'h5A5A, 18'h048D0, low};
      end
      u_pbs_bus_model.burst_order_select = order;
      u_pbs_bus_model.start(1'b0, 20'h12342, 1'b0, 4'hF, 1'b1, 36'h000000000);
      for (int k = 0; k < 3; k++)
         u_pbs_bus_model.step(pat[k]);
      for (int k = 0; k < 4; k++)
      begin
         check(dq_out, e[k]);
         if (k < 3)
            u_pbs_bus_model.step(1'b0);
      end
      u_pbs_bus_model.start(1'b0, 20'h00000, 1'b1, 4'hF, 1'b1, 36'h000000000);
   end
   endtask : s_burst
   // processor strobe opens as a read; the write rides the next burst cycle
   task automatic s_proc_write();
   begin
      u_pbs_bus_model.start(1'b1, 20'h00020, 1'b0, 4'hF, 1'b1, 36'h000000000);
      u_pbs_bus_model.beat(4'hF, 1'b0, 36'hABCDE0123);
      u_pbs_bus_model.depth_expansion_select_low_b = 1'b1;
      u_pbs_bus_model.start(1'b0, 20'h00020, 1'b0, 4'hF, 1'b1, 36'h000000000);
      u_pbs_bus_model.depth_expansion_select_low_b = 1'b0;
      rd(1'b0, 20'h00020, 36'hABCDE0123);
   end
   endtask : s_proc_write
   // sleep flushes a running burst; a processor strobe without select is ignored
   task automatic s_sleep();
   begin
      u_pbs_bus_model.start(1'b0, 20'h12341, 1'b0, 4'hF, 1'b1, 36'h000000000);
      repeat (3)
         u_pbs_bus_model.step(1'b0);
      check(dq_out, 36'h5A5A12341);
      u_pbs_bus_model.sleep_request = 1'b1;
      u_pbs_bus_model.step(1'b0);
      check(pbs_word_t'(dq_drive_b), 36'h000000000);
      u_pbs_bus_model.step(1'b0);
      check(pbs_word_t'(dq_drive_b), 36'h000000001);
      u_pbs_bus_model.sleep_request = 1'b0;
      u_pbs_bus_model.start(1'b1, 20'h12342, 1'b1, 4'hF, 1'b1, 36'h000000000);
      repeat (4)
         u_pbs_bus_model.step(1'b0);
      check(pbs_word_t'(dq_drive_b), 36'h000000001);
   end
   endtask : s_sleep
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         errors++;
         finish_test();
      end
   end
   initial
   begin
      rst_b = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      s_lanes();
      for (int j = 0; j < 4; j++)
         wr(20'h12340 + 20'(j), 4'hF, 1'b0, {16'h5A5A, 20'h12340 + 20'(j)});
      for (int m = 0; m < 4; m++)
         s_burst(m[0], m[1] ? 3'b101 : 3'b111);
      s_proc_write();
      s_sleep();
      finish_test();
   end
endmodule : pbs_sram_core_test
